//--- logic/dmu_consts.svh
// Constants for the data memory access unit: offsets, fields, resets, timing
`ifndef DMU_CONSTS_SVH
`define DMU_CONSTS_SVH
`define DMU_LOW_RAM_TOP   8'h7F
`define DMU_BITRAM_BASE   8'h20
`define DMU_IRAM_BYTES    256
`define DMU_EXPANDED_RAM_BYTES    2048
`define DMU_SFR_DPH       8'h83
`define DMU_SFR_DPL       8'h84
`define DMU_SFR_AUX       8'h8E
`define DMU_SFR_CLK       8'h8F
`define DMU_SFR_P2        8'hA0
`define DMU_SFR_AUXONE    8'hA2
`define DMU_SFR_PSW       8'hD0
`define DMU_AUX_EXTSEL    1
`define DMU_AUX_SIZE_LO   2
`define DMU_AUX_STRETCH   5
`define DMU_AUXONE_DPS    0
`define DMU_AUXONE_GF3    3
`define DMU_AUXONE_BOOT   5
`define DMU_CLK_X2        0
`define DMU_PSW_BANK_LO   3
`define DMU_AUX_RST       8'h14
`define DMU_AUXONE_RST    8'h00
`define DMU_CLK_RST       8'h00
`define DMU_PSW_RST       8'h00
`define DMU_P2_RST        8'hFF
`define DMU_PH_ADDR_CLKS  4'h1
`define DMU_PH_LATCH_CLKS 4'h1
`define DMU_STROBE_CLKS   4'h3
`define DMU_STRETCH_CLKS  4'hF
`define DMU_PH_TAIL_CLKS  4'h1
`endif

//--- logic/dmu_pkg.sv
// Types shared by the data memory access unit and its users
`include "dmu_consts.svh"
package dmu_pkg;
    typedef enum logic [2:0] {
        ACC_DIRECT, ACC_INDIRECT, ACC_REGBANK, ACC_BIT, ACC_INC_DIRECT, ACC_XDPTR, ACC_XRI
    } dmu_kind_e;
    typedef enum logic [2:0] {PH_IDLE, PH_ADDR, PH_LATCH, PH_STROBE, PH_TAIL} dmu_phase_e;
    typedef struct packed {
        dmu_kind_e   kind;
        logic        write;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        bitVal;
    } dmu_req_s;
    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       sfrMiss;
    } dmu_resp_s;
    typedef struct packed {
        logic       ale;
        logic       readStrobeN;
        logic       writeStrobeN;
        logic [7:0] p0Out;
        logic       p0OeN;
        logic [7:0] p2Out;
    } dmu_xbus_s;
    typedef struct packed {
        logic [1:0][15:0] dataPointerPair;
        logic [7:0]       auxControl;
        logic [7:0]       auxControlOne;
        logic [7:0]       clockControl;
        logic [7:0]       programStatus;
        logic [7:0]       port2Latch;
        dmu_phase_e       phase;
        logic [3:0]       phaseCnt;
        logic             tickDiv;
        logic             extWrite;
        logic             busy;
        dmu_resp_s        resp;
        dmu_xbus_s        xbus;
    } dmu_ctl_s;
    typedef struct packed {
        dmu_ctl_s                             ctl;
        logic [`DMU_IRAM_BYTES-1:0][7:0] iram;
        logic [`DMU_EXPANDED_RAM_BYTES-1:0][7:0] expanded_ram;
    } dmu_state_s;
endpackage

//--- logic/data_memory_access_unit.sv
// Data memory access unit: internal RAM map, expanded RAM, external bus, dual pointer
//
// Overview of operation
// - Low RAM 00h-7Fh answers both direct and indirect accesses.
// - Bottom 32 bytes are four banks of eight registers; bank bits pick one.
// - Bank bits 00/01/10/11 place the bank at 00h/08h/10h/18h.
// - Bytes 20h-2Fh hold 128 single bits, bit numbers 00h-7Fh.
// - Upper RAM 80h-FFh is reached by indirect accesses only.
// - Direct accesses at 80h-FFh reach the special function registers.
// - Expanded RAM of 2048 bytes at 0000h-07FFh, external moves only.
// - ext_data_select 0 routes to expanded RAM, 1 routes to the external bus.
// - expanded_ram_size_sel limits expanded RAM size; reset gives all 2048 bytes.
// - Size codes 000-101 give 256,512,768,1024,1792,2048; reset code 101.
// - RAM contents are not cleared at reset; software initialises them.
// - Address latch strobe marks a valid low address on port 0.
// - Active-low read and write strobes go to external memory.
// - An unstretched external cycle lasts six CPU clocks; CPU clock is 2 or 1 osc.
// - strobe_stretch widens the strobes from 3 to 15 CPU clocks.
// - Eight-bit indirect external accesses put the port 2 latch on port 2.
// - Two 16-bit data pointers share 83h/84h; pointer_select picks one.
// - pointer_select 0 picks the first pointer, 1 the second.
// - Incrementing the pointer_select register flips the selection.
// - Bit above the pointer_select bit always reads zero.
// - double_speed clear gives 12 osc per machine cycle, set gives 6.
`timescale 1ns/1ps
`include "dmu_consts.svh"

module data_memory_access_unit (
    input  wire logic              core_clk,
    input  wire logic              arst_n,
    input  wire logic              reqValid,
    input  wire dmu_pkg::dmu_req_s req,
    input  wire logic [7:0]        p0In,
    output logic                   busy,
    output dmu_pkg::dmu_resp_s     resp,
    output dmu_pkg::dmu_xbus_s     xbus
);
    dmu_pkg::dmu_state_s st;
    dmu_pkg::dmu_state_s next_st;

    // Control state after reset; RAM arrays are left untouched
    localparam dmu_pkg::dmu_ctl_s CTL_RST = '{
        dataPointerPair: '0,
        auxControl:      `DMU_AUX_RST,
        auxControlOne:   `DMU_AUXONE_RST,
        clockControl:    `DMU_CLK_RST,
        programStatus:   `DMU_PSW_RST,
        port2Latch:      `DMU_P2_RST,
        phase:           dmu_pkg::PH_IDLE,
        phaseCnt:        4'h0,
        tickDiv:         1'b0,
        extWrite:        1'b0,
        busy:            1'b0,
        resp:            '0,
        xbus:            '{ale: 1'b0, readStrobeN: 1'b1, writeStrobeN: 1'b1,
                           p0Out: 8'hFF, p0OeN: 1'b1, p2Out: `DMU_P2_RST}
    };

    // Expanded RAM size in bytes for a size code
    function automatic logic [11:0] eramBytes(input logic [2:0] code);
        case (code)
            3'h0:    return 12'h100;
            3'h1:    return 12'h200;
            3'h2:    return 12'h300;
            3'h3:    return 12'h400;
            3'h4:    return 12'h700;
            default: return 12'h800; // Full size, also for reserved codes
        endcase
    endfunction

    // Special function registers held by this block
    function automatic logic sfrHit(input logic [7:0] a);
        case (a)
            `DMU_SFR_DPH, `DMU_SFR_DPL, `DMU_SFR_AUX, `DMU_SFR_CLK,
            `DMU_SFR_P2, `DMU_SFR_AUXONE, `DMU_SFR_PSW: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // Read of a special function register
    function automatic logic [7:0] sfrRd(input dmu_pkg::dmu_ctl_s c, input logic [7:0] a);
        logic sel;
        sel = c.auxControlOne[`DMU_AUXONE_DPS];
        case (a)
            `DMU_SFR_DPH:    return c.dataPointerPair[sel][15:8];
            `DMU_SFR_DPL:    return c.dataPointerPair[sel][7:0];
            `DMU_SFR_AUX:    return {2'b00, c.auxControl[5:0]};
            `DMU_SFR_CLK:    return c.clockControl;
            `DMU_SFR_P2:     return c.port2Latch;
            `DMU_SFR_AUXONE: return {2'b00, c.auxControlOne[5], 1'b0,
                                     c.auxControlOne[3], 3'b000} |
                                    {7'h00, c.auxControlOne[0]};
            `DMU_SFR_PSW:    return c.programStatus;
            default:         return 8'h00;
        endcase
    endfunction

    // Write of a special function register
    function automatic dmu_pkg::dmu_ctl_s sfrWr(input dmu_pkg::dmu_ctl_s c,
                                                input logic [7:0]        a,
                                                input logic [7:0]        d);
        dmu_pkg::dmu_ctl_s r;
        logic              sel;
        r = c;
        sel = c.auxControlOne[`DMU_AUXONE_DPS];
        case (a)
            `DMU_SFR_DPH:    r.dataPointerPair[sel][15:8] = d;
            `DMU_SFR_DPL:    r.dataPointerPair[sel][7:0] = d;
            `DMU_SFR_AUX:    r.auxControl = {2'b00, d[5:0]};
            `DMU_SFR_CLK:    r.clockControl = d;
            `DMU_SFR_P2:     r.port2Latch = d;
            `DMU_SFR_AUXONE: r.auxControlOne = d & 8'h29;
            `DMU_SFR_PSW:    r.programStatus = d;
            default:         r = c;
        endcase
        return r;
    endfunction

    // Direct read: low RAM below 80h, registers above
    function automatic logic [7:0] dirRd(input dmu_pkg::dmu_state_s s, input logic [7:0] a);
        if (a <= `DMU_LOW_RAM_TOP) begin
            return s.iram[a];
        end
        return sfrRd(s.ctl, a);
    endfunction

    // Direct write: low RAM below 80h, registers above
    function automatic dmu_pkg::dmu_state_s dirWr(input dmu_pkg::dmu_state_s s,
                                                  input logic [7:0]          a,
                                                  input logic [7:0]          d);
        dmu_pkg::dmu_state_s r;
        r = s;
        if (a <= `DMU_LOW_RAM_TOP) begin
            r.iram[a] = d;
        end else begin
            r.ctl = sfrWr(s.ctl, a, d);
        end
        return r;
    endfunction

    // Cycles each bus phase lasts, in CPU clocks
    function automatic logic [3:0] phaseLen(input dmu_pkg::dmu_phase_e p, input logic stretch);
        case (p)
            dmu_pkg::PH_ADDR:   return `DMU_PH_ADDR_CLKS;
            dmu_pkg::PH_LATCH:  return `DMU_PH_LATCH_CLKS;
            dmu_pkg::PH_STROBE: return stretch ? `DMU_STRETCH_CLKS : `DMU_STROBE_CLKS;
            default:            return `DMU_PH_TAIL_CLKS;
        endcase
    endfunction

    logic       cpuTick;
    logic       stretch;
    logic [7:0] byteAddr;
    logic [7:0] byteVal;
    logic [15:0] xAddr;
    logic       lastClk;

    // Next state: request decode, register access and external bus sequencing
    always_comb begin
        next_st = st;
        next_st.ctl.resp.valid = 1'b0;
        cpuTick = st.ctl.clockControl[`DMU_CLK_X2] | st.ctl.tickDiv;
        stretch = st.ctl.auxControl[`DMU_AUX_STRETCH];
        byteAddr = {1'b0, req.addr[6:3]} + `DMU_BITRAM_BASE;
        byteVal = 8'h00;
        xAddr = req.addr;
        lastClk = cpuTick && (st.ctl.phaseCnt == phaseLen(st.ctl.phase, stretch) - 4'h1);
        if (!st.ctl.busy && reqValid) begin
            next_st.ctl.resp.valid = 1'b1;
            next_st.ctl.resp.sfrMiss = 1'b0;
            next_st.ctl.resp.data = 8'h00;
            case (req.kind)
                dmu_pkg::ACC_DIRECT: begin
                    next_st.ctl.resp.sfrMiss = req.addr[7] && !sfrHit(req.addr[7:0]);
                    if (req.write) begin
                        next_st = dirWr(st, req.addr[7:0], req.wdata);
                        next_st.ctl.resp.valid = 1'b1;
                        next_st.ctl.resp.sfrMiss = req.addr[7] && !sfrHit(req.addr[7:0]);
                        next_st.ctl.resp.data = 8'h00;
                    end else begin
                        next_st.ctl.resp.data = dirRd(st, req.addr[7:0]);
                    end
                end
                dmu_pkg::ACC_INDIRECT: begin
                    if (req.write) begin
                        next_st.iram[req.addr[7:0]] = req.wdata;
                    end else begin
                        next_st.ctl.resp.data = st.iram[req.addr[7:0]];
                    end
                end
                dmu_pkg::ACC_REGBANK: begin
                    byteAddr = {3'b000, st.ctl.programStatus[`DMU_PSW_BANK_LO +: 2],
                                req.addr[2:0]};
                    if (req.write) begin
                        next_st.iram[byteAddr] = req.wdata;
                    end else begin
                        next_st.ctl.resp.data = st.iram[byteAddr];
                    end
                end
                dmu_pkg::ACC_BIT: begin
                    if (req.addr[7]) begin
                        byteAddr = {req.addr[7:3], 3'b000};
                    end
                    byteVal = dirRd(st, byteAddr);
                    next_st.ctl.resp.data = {7'h00, byteVal[req.addr[2:0]]};
                    next_st.ctl.resp.sfrMiss = req.addr[7] && !sfrHit(byteAddr);
                    if (req.write) begin
                        byteVal[req.addr[2:0]] = req.bitVal;
                        next_st = dirWr(st, byteAddr, byteVal);
                        next_st.ctl.resp.valid = 1'b1;
                        next_st.ctl.resp.sfrMiss = req.addr[7] && !sfrHit(byteAddr);
                        next_st.ctl.resp.data = 8'h00;
                    end
                end
                dmu_pkg::ACC_INC_DIRECT: begin
                    byteVal = dirRd(st, req.addr[7:0]) + 8'h01;
                    next_st = dirWr(st, req.addr[7:0], byteVal);
                    next_st.ctl.resp.valid = 1'b1;
                    next_st.ctl.resp.sfrMiss = req.addr[7] && !sfrHit(req.addr[7:0]);
                    next_st.ctl.resp.data = byteVal;
                end
                default: begin
                    if (req.kind == dmu_pkg::ACC_XDPTR) begin
                        xAddr = st.ctl.dataPointerPair[st.ctl.auxControlOne[`DMU_AUXONE_DPS]];
                    end else begin
                        xAddr = {8'h00, req.addr[7:0]};
                    end
                    if (!st.ctl.auxControl[`DMU_AUX_EXTSEL] &&
                        ({4'h0, xAddr[11:0]} < {4'h0, eramBytes(
                            st.ctl.auxControl[`DMU_AUX_SIZE_LO +: 3])}) &&
                        xAddr[15:12] == 4'h0) begin
                        if (req.write) begin
                            next_st.expanded_ram[xAddr[10:0]] = req.wdata;
                        end else begin
                            next_st.ctl.resp.data = st.expanded_ram[xAddr[10:0]];
                        end
                    end else begin
                        next_st.ctl.resp.valid = 1'b0;
                        next_st.ctl.busy = 1'b1;
                        next_st.ctl.extWrite = req.write;
                        next_st.ctl.phase = dmu_pkg::PH_ADDR;
                        next_st.ctl.phaseCnt = 4'h0;
                        next_st.ctl.xbus.ale = 1'b1;
                        next_st.ctl.xbus.p0Out = xAddr[7:0];
                        next_st.ctl.xbus.p0OeN = 1'b0;
                        next_st.ctl.xbus.p2Out = (req.kind == dmu_pkg::ACC_XRI) ?
                            st.ctl.port2Latch : xAddr[15:8];
                        next_st.ctl.resp.data = req.wdata;
                    end
                end
            endcase
        end else if (st.ctl.busy && cpuTick) begin
            next_st.ctl.phaseCnt = st.ctl.phaseCnt + 4'h1;
            if (lastClk) begin
                next_st.ctl.phaseCnt = 4'h0;
                case (st.ctl.phase)
                    dmu_pkg::PH_ADDR: begin
                        next_st.ctl.phase = dmu_pkg::PH_LATCH;
                        next_st.ctl.xbus.ale = 1'b0;
                    end
                    dmu_pkg::PH_LATCH: begin
                        next_st.ctl.phase = dmu_pkg::PH_STROBE;
                        if (st.ctl.extWrite) begin
                            next_st.ctl.xbus.p0Out = st.ctl.resp.data;
                            next_st.ctl.xbus.writeStrobeN = 1'b0;
                        end else begin
                            next_st.ctl.xbus.p0OeN = 1'b1;
                            next_st.ctl.xbus.readStrobeN = 1'b0;
                        end
                    end
                    dmu_pkg::PH_STROBE: begin
                        next_st.ctl.phase = dmu_pkg::PH_TAIL;
                        next_st.ctl.xbus.readStrobeN = 1'b1;
                        next_st.ctl.xbus.writeStrobeN = 1'b1;
                        if (!st.ctl.extWrite) begin
                            next_st.ctl.resp.data = p0In;
                        end
                    end
                    dmu_pkg::PH_TAIL: begin
                        next_st.ctl.phase = dmu_pkg::PH_IDLE;
                        next_st.ctl.busy = 1'b0;
                        next_st.ctl.xbus.p0OeN = 1'b1;
                        next_st.ctl.xbus.p0Out = 8'hFF;
                        next_st.ctl.xbus.p2Out = st.ctl.port2Latch;
                        next_st.ctl.resp.valid = 1'b1;
                        next_st.ctl.resp.sfrMiss = 1'b0;
                        if (st.ctl.extWrite) begin
                            next_st.ctl.resp.data = 8'h00;
                        end
                    end
                    default: begin
                        next_st.ctl.phase = dmu_pkg::PH_IDLE;
                        next_st.ctl.busy = 1'b0;
                    end
                endcase
            end
        end else if (!st.ctl.busy) begin
            next_st.ctl.xbus.p2Out = st.ctl.port2Latch;
        end
        // Divider set last, so whole-state writes above cannot stall it
        next_st.ctl.tickDiv = ~st.ctl.tickDiv;
    end

    // State register; RAM contents are not cleared by reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            st.ctl <= CTL_RST;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state flops
    assign busy = st.ctl.busy;
    assign resp = st.ctl.resp;
    assign xbus = st.ctl.xbus;
endmodule

//--- tb/dmu_checker.sv
// Port-level checks of the data memory access unit
`timescale 1ns/1ps
module dmu_checker (
    input wire logic               core_clk,
    input wire logic               arst_n,
    input wire logic               reqValid,
    input wire dmu_pkg::dmu_req_s  req,
    input wire logic [7:0]         p0In,
    input wire logic               busy,
    input wire dmu_pkg::dmu_resp_s resp,
    input wire dmu_pkg::dmu_xbus_s xbus
);
    logic [5:0] lowCnt;
    wire        anyLow = !xbus.readStrobeN || !xbus.writeStrobeN;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    // Strobe low time in core clocks
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n)
            lowCnt <= 6'h00;
        else
            lowCnt <= anyLow ? lowCnt + 6'h01 : 6'h00;
    end
    // Bus cycle steps
    sequence s_latchEnd; $fell(xbus.ale); endsequence
    sequence s_strobeOn; anyLow; endsequence
    sequence s_strobeEnd; $fell(anyLow); endsequence
    a_ale_drives_addr:
        assert property (xbus.ale |-> !xbus.p0OeN) else $error("ale without address");
    a_ale_short:
        assert property (xbus.ale ##1 xbus.ale |=> !xbus.ale) else $error("ale too long");
    a_strobes_apart:
        assert property (xbus.readStrobeN || xbus.writeStrobeN) else $error("both strobes");
    a_read_releases:
        assert property (!xbus.readStrobeN |-> xbus.p0OeN) else $error("port 0 driven in read");
    a_write_drives:
        assert property (!xbus.writeStrobeN |-> !xbus.p0OeN) else $error("write data absent");
    a_high_held:
        assert property (anyLow && $past(anyLow) |-> $stable(xbus.p2Out))
            else $error("high address moved");
    a_strobe_width:
        assert property (s_strobeEnd |-> lowCnt inside {6'd3, 6'd6, 6'd15, 6'd30})
            else $error("strobe width wrong");
    a_latch_strobe:
        assert property (s_latchEnd |-> ##[1:3] s_strobeOn) else $error("strobe late");
    a_tail_resp:
        assert property (s_strobeEnd |-> ##[1:3] resp.valid) else $error("answer late");
    a_idle_quiet:
        assert property (!busy |-> xbus.readStrobeN && xbus.writeStrobeN && !xbus.ale)
            else $error("bus active while idle");
endmodule
bind data_memory_access_unit dmu_checker u_dmu_checker (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .reqValid (reqValid),
    .req      (req),
    .p0In     (p0In),
    .busy     (busy),
    .resp     (resp),
    .xbus     (xbus)
);

//--- tb/dmu_ext_mem.sv
// External data memory with transparent address latch on the muxed bus
`timescale 1ns/1ps
module dmu_ext_mem (
    input  wire logic               core_clk,
    input  wire dmu_pkg::dmu_xbus_s xbus,
    output logic [7:0]              p0In,
    output logic [15:0]             lastAddr
);
    logic [7:0]  mem [0:65535];
    logic [7:0]  lowLatch = 8'h00;
    logic [7:0]  lastLine = 8'h00;
    logic        prevWr   = 1'b1;
    wire  [15:0] addr     = {xbus.p2Out, lowLatch};
    initial lastAddr = 16'h0000;
    // Latch follows port 0 while ale high, holds after it falls
    always @(posedge core_clk) begin
        prevWr <= xbus.writeStrobeN;
        if (xbus.ale)
            lowLatch <= xbus.p0Out;
        if (!xbus.readStrobeN || !xbus.writeStrobeN)
            lastAddr <= addr;
        if (!xbus.readStrobeN)
            lastLine <= mem[addr];
        if (!prevWr && xbus.writeStrobeN)
            mem[addr] <= xbus.p0Out;
    end
    // Drive data only under read strobe, otherwise the complement of the last line read
    assign p0In = xbus.readStrobeN ? ~lastLine : mem[addr];
endmodule

//--- tb/tb.sv
// Self-checking bench for the data memory access unit
`timescale 1ns/1ps
`include "dmu_consts.svh"
module tb;
    localparam dmu_pkg::dmu_kind_e DIR = dmu_pkg::ACC_DIRECT;
    localparam dmu_pkg::dmu_kind_e XP  = dmu_pkg::ACC_XDPTR;
    logic               core_clk;
    logic               arst_n;
    logic               reqValid;
    dmu_pkg::dmu_req_s  req;
    logic [7:0]         p0In;
    logic               busy;
    dmu_pkg::dmu_resp_s resp;
    dmu_pkg::dmu_xbus_s xbus;
    logic [15:0]        lastAddr;
    logic [7:0]         rd;
    logic               miss;
    int                 busyCnt;
    int                 failures;
    int                 total_checks;
    data_memory_access_unit u_data_memory_access_unit (.core_clk(core_clk), .arst_n(arst_n),
        .reqValid(reqValid), .req(req), .p0In(p0In), .busy(busy), .resp(resp), .xbus(xbus));
    dmu_ext_mem u_dmu_ext_mem (.core_clk(core_clk), .xbus(xbus), .p0In(p0In),
        .lastAddr(lastAddr));
    // Clock
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    task automatic final_report();
        if (failures == 0 && total_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic check8(input string name, input logic [7:0] exp, input logic [7:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic checkCnt(input string name, input int exp, input int got);
        total_checks++;
        if (got < exp - 1 || got > exp + 1) begin
            failures++;
            $display("CHECK FAILED %s expected %0d seen %0d", name, exp, got);
        end
    endtask
    // One request, held one edge, then a bounded wait for the answer
    task automatic access(input dmu_pkg::dmu_kind_e k, input logic w, input logic [15:0] a,
                          input logic [7:0] d, input logic b);
        int n;
        @(posedge core_clk);
        reqValid <= 1'b1;
        req      <= '{kind: k, write: w, addr: a, wdata: d, bitVal: b};
        @(posedge core_clk);
        reqValid <= 1'b0;
        busyCnt = 0;
        n = 0;
        do begin
            @(negedge core_clk);
            if (busy === 1'b1)
                busyCnt++;
            n++;
        end while (resp.valid !== 1'b1 && n < 80);
        if (resp.valid !== 1'b1) begin
            failures++;
            final_report();
        end
        rd = resp.data;
        miss = resp.sfrMiss;
    endtask
    task automatic put(input dmu_pkg::dmu_kind_e k, input logic [15:0] a, input logic [7:0] d);
        access(k, 1'b1, a, d, 1'b0);
    endtask
    task automatic get(input dmu_pkg::dmu_kind_e k, input logic [15:0] a);
        access(k, 1'b0, a, 8'h00, 1'b0);
    endtask
    task automatic s_segments();
        get(DIR, `DMU_SFR_AUX);
        check8("aux reset", 8'h14, rd);
        for (int b = 0; b < 4; b++) begin
            put(DIR, `DMU_SFR_PSW, 8'(b << 3));
            put(dmu_pkg::ACC_REGBANK, 16'h0005, 8'(8'hA0 + b));
        end
        for (int b = 0; b < 4; b++) begin
            get(DIR, 16'(b * 8 + 5));
            check8("bank register", 8'(8'hA0 + b), rd);
        end
        put(DIR, 16'h007F, 8'h5A);
        get(dmu_pkg::ACC_INDIRECT, 16'h007F);
        check8("low ram", 8'h5A, rd);
        put(dmu_pkg::ACC_INDIRECT, 16'h0090, 8'hC3);
        get(DIR, 16'h0090);
        check8("direct upper", 8'h01, {7'h00, miss});
        get(dmu_pkg::ACC_INDIRECT, 16'h0090);
        check8("upper ram", 8'hC3, rd);
        put(DIR, 16'h002F, 8'h00);
        access(dmu_pkg::ACC_BIT, 1'b1, 16'h007F, 8'h00, 1'b1);
        get(DIR, 16'h002F);
        check8("bit area", 8'h80, rd);
    endtask
    task automatic s_pointers();
        put(DIR, `DMU_SFR_DPH, 8'h12);
        get(dmu_pkg::ACC_INC_DIRECT, `DMU_SFR_AUXONE);
        put(DIR, `DMU_SFR_DPH, 8'h56);
        put(DIR, `DMU_SFR_AUXONE, 8'h0D);
        get(DIR, `DMU_SFR_AUXONE);
        check8("select reg", 8'h09, rd & 8'h0D);
        get(DIR, `DMU_SFR_DPH);
        check8("second pointer", 8'h56, rd);
        get(dmu_pkg::ACC_INC_DIRECT, `DMU_SFR_AUXONE);
        get(DIR, `DMU_SFR_AUXONE);
        check8("select toggled", 8'h08, rd & 8'h0D);
        get(DIR, `DMU_SFR_DPH);
        check8("first pointer", 8'h12, rd);
    endtask
    task automatic s_memory();
        put(DIR, `DMU_SFR_DPH, 8'h01);
        put(DIR, `DMU_SFR_DPL, 8'h10);
        put(XP, 16'h0000, 8'h6E);
        get(XP, 16'h0000);
        check8("expanded ram", 8'h6E, rd);
        check8("no bus cycle", 8'h00, 8'(busyCnt));
        put(DIR, `DMU_SFR_AUX, 8'h00);
        put(XP, 16'h0000, 8'h77);
        check8("beyond size", 8'h01, lastAddr[15:8]);
        put(DIR, `DMU_SFR_AUX, 8'h10);
        put(DIR, `DMU_SFR_DPH, 8'h07);
        put(DIR, `DMU_SFR_DPL, 8'h00);
        put(XP, 16'h0000, 8'h99);
        check8("size boundary", 8'h07, lastAddr[15:8]);
        put(DIR, `DMU_SFR_AUX, 8'h16);
        put(DIR, `DMU_SFR_DPH, 8'h12);
        put(DIR, `DMU_SFR_DPL, 8'h34);
        put(XP, 16'h0000, 8'hA5);
        checkCnt("standard cycle", 12, busyCnt);
        get(XP, 16'h0000);
        check8("external read", 8'hA5, rd);
        check8("low address", 8'h34, lastAddr[7:0]);
        put(DIR, `DMU_SFR_CLK, 8'h01);
        put(XP, 16'h0000, 8'h5B);
        checkCnt("double speed cycle", 6, busyCnt);
        put(DIR, `DMU_SFR_AUX, 8'h36);
        get(XP, 16'h0000);
        check8("stretched read", 8'h5B, rd);
        checkCnt("stretched cycle", 18, busyCnt);
        put(DIR, `DMU_SFR_P2, 8'h3C);
        put(dmu_pkg::ACC_XRI, 16'h0055, 8'hE1);
        check8("port 2 latch", 8'h3C, lastAddr[15:8]);
    endtask
    // Reset, then the scenarios
    initial begin
        arst_n = 1'b0;
        reqValid = 1'b0;
        req = '0;
        failures = 0;
        total_checks = 0;
        repeat (3) @(posedge core_clk);
        arst_n <= 1'b1;
        s_segments();
        s_pointers();
        s_memory();
        final_report();
    end
endmodule
